/* hw/tw_pkg.sv */
// shared constants and types for the three-wire register port
package tw_pkg;
    localparam int CLK_PERIOD_NS = 40;
    localparam int SCLK_PERIOD_NS = 320;
    // least half period, rounded up to whole system cycles
    localparam int SCLK_HALF_CYC =
        (SCLK_PERIOD_NS + 2 * CLK_PERIOD_NS - 1) / (2 * CLK_PERIOD_NS);
    localparam int GAP_CYC = 4 * SCLK_HALF_CYC;
    localparam logic [7:0] HALF_LOAD = 8'(SCLK_HALF_CYC - 1);
    localparam logic [7:0] GAP_LOAD = 8'(GAP_CYC - 1);
    localparam int ADDR_W = 13;
    localparam int RW_POS = 7;
    localparam int LEN_HI_POS = 6;
    localparam int LEN_LO_POS = 5;
    localparam int ADDR_TOP_POS = 4;
    localparam logic [2:0] LAST_BIT = 3'h7;
    localparam logic [1:0] LEN_MANY = 2'h3;
    localparam logic [2:0] BYTE_SAT = 3'h4;
    localparam logic [ADDR_W-1:0] ADDR_RST = 13'h0000;
    localparam logic [7:0] BYTE_RST = 8'h00;
    typedef enum logic [1:0] {
        TW_D_IDLE,
        TW_D_INSTR,
        TW_D_DATA
    } tw_dev_state_t;
    typedef enum logic [2:0] {
        TW_H_IDLE,
        TW_H_LOW,
        TW_H_HIGH,
        TW_H_TAIL,
        TW_H_GAP
    } tw_host_state_t;
endpackage

/* hw/tw_link_if.sv */
// three-wire link between host and device
`timescale 1ns/1ps
interface tw_link_if;
    logic sel_n;
    logic sclk;
    logic host_sdio_out;
    logic host_sdio_oe;
    logic dev_sdio_out;
    logic dev_sdio_oe;
    logic sdio;
    // shared data wire, weak pull-up when nobody drives
    assign sdio = host_sdio_oe ? host_sdio_out :
                  (dev_sdio_oe ? dev_sdio_out : 1'b1);
    modport host (
        output sel_n,
        output sclk,
        output host_sdio_out,
        output host_sdio_oe,
        input sdio
    );
    modport dev (
        input sel_n,
        input sclk,
        input sdio,
        output dev_sdio_out,
        output dev_sdio_oe
    );
endinterface

/* hw/tw_dev.sv */
// device end of the three-wire register port
`timescale 1ns/1ps
module tw_dev (
    input wire logic clk_sys_in,
    input wire logic resetn_in,
    tw_link_if.dev link,
    input wire logic [7:0] reg_rdata_in,
    output logic [tw_pkg::ADDR_W-1:0] reg_addr_out,
    output logic [7:0] reg_wdata_out,
    output logic reg_wr_out,
    output logic reg_rd_out,
    output logic frame_active_out
);
    import tw_pkg::*;

    logic [1:0] sel_sync;
    logic [1:0] sclk_sync;
    logic [1:0] sdio_sync;
    logic sel_prev;
    logic sclk_prev;
    logic rise;
    logic fall;
    logic start;
    logic sel_high;
    logic [7:0] next_byte;
    tw_dev_state_t state;
    logic [2:0] bit_cnt;
    logic second;
    logic hdr_rw;
    logic [1:0] hdr_len;
    logic [4:0] hdr_addr_hi;
    logic [ADDR_W-1:0] addr;
    logic [2:0] byte_cnt;
    logic [7:0] shift;
    logic [7:0] tx;
    logic load_pend;
    logic byte_done;
    logic in_range;
    logic next_in_range;
    logic [ADDR_W-1:0] first_addr;

    // pins come from the host domain, two flops before use
    always_ff @(posedge clk_sys_in or negedge resetn_in) begin
        if (!resetn_in) begin
            sel_sync <= 2'h3;
            sclk_sync <= 2'h0;
            sdio_sync <= 2'h3;
            sel_prev <= 1'b1;
            sclk_prev <= 1'b0;
        end else begin
            sel_sync <= {sel_sync[0], link.sel_n};
            sclk_sync <= {sclk_sync[0], link.sclk};
            sdio_sync <= {sdio_sync[0], link.sdio};
            sel_prev <= sel_sync[1];
            sclk_prev <= sclk_sync[1];
        end
    end

    assign sel_high = sel_sync[1];
    assign start = sel_prev & ~sel_sync[1];
    // only edges seen while selected count as shift edges
    assign rise = sclk_sync[1] & ~sclk_prev & ~sel_high;
    assign fall = ~sclk_sync[1] & sclk_prev & ~sel_high;
    assign next_byte = {shift[6:0], sdio_sync[1]};
    assign byte_done = rise && (bit_cnt == LAST_BIT);
    // codes below the top one limit bytes acted upon
    assign in_range = (hdr_len == LEN_MANY) ||
                      (byte_cnt <= {1'b0, hdr_len});
    assign next_in_range = (hdr_len == LEN_MANY) ||
                           (byte_cnt < {1'b0, hdr_len});
    assign first_addr = {hdr_addr_hi, next_byte};

    // frame sequencing
    always_ff @(posedge clk_sys_in or negedge resetn_in) begin
        if (!resetn_in) begin
            state <= TW_D_IDLE;
        end else if (sel_high) begin
            state <= TW_D_IDLE;
        end else begin
            case (state)
                TW_D_IDLE: begin
                    if (start) begin
                        state <= TW_D_INSTR;
                    end
                end
                TW_D_INSTR: begin
                    if (byte_done && second) begin
                        state <= TW_D_DATA;
                    end
                end
                TW_D_DATA: begin
                    state <= TW_D_DATA;
                end
                default: begin
                    state <= TW_D_IDLE;
                end
            endcase
        end
    end

    // bit and byte counting, incoming shift register
    always_ff @(posedge clk_sys_in or negedge resetn_in) begin
        if (!resetn_in) begin
            bit_cnt <= 3'h0;
            second <= 1'b0;
            byte_cnt <= 3'h0;
            shift <= BYTE_RST;
        end else if (sel_high || state == TW_D_IDLE) begin
            // a partial byte left at select high is simply lost
            bit_cnt <= 3'h0;
            second <= 1'b0;
            byte_cnt <= 3'h0;
            shift <= BYTE_RST;
        end else if (rise) begin
            shift <= next_byte;
            bit_cnt <= bit_cnt + 3'h1;
            if (bit_cnt == LAST_BIT) begin
                if (state == TW_D_INSTR) begin
                    second <= 1'b1;
                end else if (byte_cnt != BYTE_SAT) begin
                    byte_cnt <= byte_cnt + 3'h1;
                end
            end
        end
    end

    // instruction header capture
    always_ff @(posedge clk_sys_in or negedge resetn_in) begin
        if (!resetn_in) begin
            hdr_rw <= 1'b0;
            hdr_len <= 2'h0;
            hdr_addr_hi <= 5'h00;
        end else if (byte_done && state == TW_D_INSTR && !second) begin
            hdr_rw <= next_byte[RW_POS];
            hdr_len <= {next_byte[LEN_HI_POS],
                        next_byte[LEN_LO_POS]};
            hdr_addr_hi <= next_byte[ADDR_TOP_POS:0];
        end
    end

    // address counter and register strobes
    always_ff @(posedge clk_sys_in or negedge resetn_in) begin
        if (!resetn_in) begin
            addr <= ADDR_RST;
            reg_addr_out <= ADDR_RST;
            reg_wdata_out <= BYTE_RST;
            reg_wr_out <= 1'b0;
            reg_rd_out <= 1'b0;
        end else begin
            reg_wr_out <= 1'b0;
            reg_rd_out <= 1'b0;
            if (byte_done && state == TW_D_INSTR && second) begin
                addr <= first_addr;
                reg_addr_out <= first_addr;
                reg_rd_out <= hdr_rw;
            end else if (byte_done && state == TW_D_DATA) begin
                addr <= addr + 13'h0001;
                if (!hdr_rw) begin
                    reg_addr_out <= addr;
                    reg_wdata_out <= next_byte;
                    reg_wr_out <= in_range;
                end else begin
                    // prefetch next read only while count allows
                    reg_addr_out <= addr + 13'h0001;
                    reg_rd_out <= next_in_range;
                end
            end
        end
    end

    // read data out, driven after each falling clock edge
    always_ff @(posedge clk_sys_in or negedge resetn_in) begin
        if (!resetn_in) begin
            tx <= BYTE_RST;
            load_pend <= 1'b0;
            link.dev_sdio_out <= 1'b1;
        end else if (sel_high) begin
            load_pend <= 1'b0;
            tx <= BYTE_RST;
        end else begin
            if (fall && state == TW_D_DATA && hdr_rw) begin
                if (load_pend) begin
                    link.dev_sdio_out <= reg_rdata_in[7];
                    tx <= {reg_rdata_in[6:0], 1'b0};
                    load_pend <= 1'b0;
                end else begin
                    link.dev_sdio_out <= tx[7];
                    tx <= {tx[6:0], 1'b0};
                end
            end
            // a fresh fetch wins over the clear
            if (reg_rd_out) begin
                load_pend <= 1'b1;
            end
        end
    end

    // wire ownership: only in read data phase, until select high
    always_ff @(posedge clk_sys_in or negedge resetn_in) begin
        if (!resetn_in) begin
            link.dev_sdio_oe <= 1'b0;
        end else if (sel_high) begin
            link.dev_sdio_oe <= 1'b0;
        end else if (fall && state == TW_D_DATA && hdr_rw) begin
            link.dev_sdio_oe <= 1'b1;
        end
    end

    always_ff @(posedge clk_sys_in or negedge resetn_in) begin
        if (!resetn_in) begin
            frame_active_out <= 1'b0;
        end else begin
            frame_active_out <= ~sel_high;
        end
    end
endmodule

/* hw/tw_host.sv */
// host end of the three-wire register port
`timescale 1ns/1ps
module tw_host (
    input wire logic clk_sys_in,
    input wire logic resetn_in,
    tw_link_if.host link,
    input wire logic cmd_valid_in,
    input wire logic cmd_read_in,
    input wire logic [tw_pkg::ADDR_W-1:0] cmd_addr_in,
    input wire logic [7:0] cmd_count_in,
    input wire logic [7:0] wdata_in,
    output logic cmd_ready_out,
    output logic wdata_take_out,
    output logic [7:0] rdata_out,
    output logic rdata_valid_out,
    output logic done_out
);
    import tw_pkg::*;

    tw_host_state_t state;
    logic [1:0] sdio_sync;
    logic [7:0] half_cnt;
    logic tick;
    logic [2:0] bit_idx;
    logic [8:0] byte_idx;
    logic [7:0] nbytes;
    logic is_read;
    logic [7:0] hdr1;
    logic [7:0] tx;
    logic [7:0] rx;
    logic [7:0] next_rx;
    logic [1:0] len_code;
    logic [7:0] cnt_eff;

    assign tick = (half_cnt == 8'h00);
    assign next_rx = {rx[6:0], sdio_sync[1]};
    assign cnt_eff = (cmd_count_in == 8'h00) ? 8'h01 : cmd_count_in;
    // counts of four and above all share the top code
    assign len_code = (cnt_eff > 8'h03) ? LEN_MANY :
                      2'(cnt_eff - 8'h01);

    always_ff @(posedge clk_sys_in or negedge resetn_in) begin
        if (!resetn_in) begin
            sdio_sync <= 2'h3;
        end else begin
            sdio_sync <= {sdio_sync[0], link.sdio};
        end
    end

    always_ff @(posedge clk_sys_in or negedge resetn_in) begin
        if (!resetn_in) begin
            state <= TW_H_IDLE;
            half_cnt <= HALF_LOAD;
            bit_idx <= 3'h0;
            byte_idx <= 9'h000;
            nbytes <= 8'h01;
            is_read <= 1'b0;
            hdr1 <= BYTE_RST;
            tx <= BYTE_RST;
            rx <= BYTE_RST;
            link.sel_n <= 1'b1;
            link.sclk <= 1'b0;
            link.host_sdio_out <= 1'b1;
            link.host_sdio_oe <= 1'b0;
            cmd_ready_out <= 1'b1;
            wdata_take_out <= 1'b0;
            rdata_out <= BYTE_RST;
            rdata_valid_out <= 1'b0;
            done_out <= 1'b0;
        end else begin
            wdata_take_out <= 1'b0;
            rdata_valid_out <= 1'b0;
            done_out <= 1'b0;
            half_cnt <= tick ? HALF_LOAD : half_cnt - 8'h01;
            case (state)
                TW_H_IDLE: begin
                    if (cmd_valid_in) begin
                        // select falls with first bit already on the wire
                        state <= TW_H_LOW;
                        half_cnt <= HALF_LOAD;
                        cmd_ready_out <= 1'b0;
                        link.sel_n <= 1'b0;
                        is_read <= cmd_read_in;
                        nbytes <= cnt_eff;
                        hdr1 <= cmd_addr_in[7:0];
                        tx <= {cmd_read_in, len_code, cmd_addr_in[12:8]};
                        link.host_sdio_out <= cmd_read_in;
                        link.host_sdio_oe <= 1'b1;
                        bit_idx <= 3'h0;
                        byte_idx <= 9'h000;
                    end
                end
                TW_H_LOW: begin
                    if (tick) begin
                        link.sclk <= 1'b1;
                        state <= TW_H_HIGH;
                    end
                end
                TW_H_HIGH: begin
                    if (tick) begin
                        link.sclk <= 1'b0;
                        rx <= next_rx;
                        state <= TW_H_LOW;
                        bit_idx <= bit_idx + 3'h1;
                        if (bit_idx != LAST_BIT) begin
                            link.host_sdio_out <= tx[6];
                            tx <= {tx[6:0], 1'b0};
                        end else begin
                            if (is_read && byte_idx > 9'h001) begin
                                rdata_out <= next_rx;
                                rdata_valid_out <= 1'b1;
                            end
                            byte_idx <= byte_idx + 9'h001;
                            if (byte_idx == {1'b0, nbytes} + 9'h001) begin
                                // whole bytes only, then select rises
                                state <= TW_H_TAIL;
                                link.host_sdio_oe <= 1'b0;
                            end else if (byte_idx == 9'h000) begin
                                tx <= hdr1;
                                link.host_sdio_out <= hdr1[7];
                            end else if (!is_read) begin
                                tx <= wdata_in;
                                link.host_sdio_out <= wdata_in[7];
                                wdata_take_out <= 1'b1;
                            end else begin
                                link.host_sdio_oe <= 1'b0;
                            end
                        end
                    end
                end
                TW_H_TAIL: begin
                    if (tick) begin
                        link.sel_n <= 1'b1;
                        half_cnt <= GAP_LOAD;
                        state <= TW_H_GAP;
                    end
                end
                TW_H_GAP: begin
                    if (tick) begin
                        done_out <= 1'b1;
                        cmd_ready_out <= 1'b1;
                        state <= TW_H_IDLE;
                    end
                end
                default: begin
                    state <= TW_H_IDLE;
                end
            endcase
        end
    end
endmodule

/* hw/tw_end.sv */
// no logic of its own; each end sits in its own file
`timescale 1ns/1ps

/* tb/tw_checker.sv */
// concurrent checks on the three-wire link
`timescale 1ns/1ps
module tw_checker (
    input wire logic clk_sys_in,
    input wire logic resetn_in,
    input wire logic sel_n,
    input wire logic sclk,
    input wire logic host_sdio_out,
    input wire logic host_sdio_oe,
    input wire logic dev_sdio_out,
    input wire logic dev_sdio_oe,
    input wire logic sdio
);
    default clocking cb @(posedge clk_sys_in);
    endclocking
    default disable iff (!resetn_in);
    logic sclk_q;
    logic [7:0] rise_cnt;
    // rises per frame; wraps past 31 bytes, fine for short frames
    always_ff @(posedge clk_sys_in or negedge resetn_in) begin
        if (!resetn_in) begin
            sclk_q <= 1'b0;
            rise_cnt <= 8'h00;
        end else begin
            sclk_q <= sclk;
            if (sel_n) begin
                rise_cnt <= 8'h00;
            end else if (sclk && !sclk_q) begin
                rise_cnt <= rise_cnt + 8'h01;
            end
        end
    end
    sequence lead_in_s;
        !sclk [*4] ##1 sclk;
    endsequence
    sequence high_half_s;
        sclk [*4] ##1 !sclk;
    endsequence
    idle_clock_a: assert property (sel_n |-> !sclk)
        else $error("link clock moved outside a frame");
    frame_start_a: assert property ($fell(sel_n) |-> lead_in_s)
        else $error("first clock rise not four cycles after select");
    half_period_a: assert property ($rose(sclk) |-> high_half_s)
        else $error("link clock high half not four cycles");
    one_driver_a: assert property (!(host_sdio_oe && dev_sdio_oe))
        else $error("both ends drive the data wire");
    host_leads_a: assert property ($fell(sel_n) |-> host_sdio_oe)
        else $error("host not driving at frame start");
    dev_release_a: assert property (sel_n [*5] |-> !dev_sdio_oe)
        else $error("device still drives after select high");
    dev_turn_a: assert property ($rose(dev_sdio_oe) |->
        !sel_n && rise_cnt == 8'h10)
        else $error("device drove before instruction end");
    whole_bytes_a: assert property ($rose(sel_n) |->
        rise_cnt[2:0] == 3'h0 && rise_cnt >= 8'h10)
        else $error("frame not whole bytes after instruction");
    data_steady_a: assert property (sclk && $past(sclk) |->
        $stable(sdio))
        else $error("data wire moved while clock high");
endmodule

/* tb/three_wire_register_port_bench.sv */
// self-checking bench joining host and device ends
`timescale 1ns/1ps
module three_wire_register_port_bench;
    import tw_pkg::*;
    logic clk_sys_in = 1'b0;
    logic resetn_in = 1'b0;
    logic cmd_valid = 1'b0;
    logic cmd_read = 1'b0;
    logic [ADDR_W-1:0] cmd_addr = 13'h0000;
    logic [7:0] cmd_count = 8'h01;
    logic [7:0] wdata = 8'h00;
    logic cmd_ready, wdata_take, rdata_valid, done;
    logic reg_wr, reg_rd, frame_active;
    logic [7:0] rdata, reg_wdata;
    logic [ADDR_W-1:0] reg_addr;
    logic [15:0] instr = 16'h0000;
    logic sclk_q = 1'b0;
    int nbits = 0;
    int err_total = 0;
    int n_checks = 0;
    logic [ADDR_W-1:0] wa_q[$];
    logic [7:0] wd_q[$];
    logic [7:0] rd_q[$];
    logic [ADDR_W-1:0] ra_q[$];
    logic hung = 1'b0;
    // register file stand-in: value derived from address
    wire logic [7:0] reg_rdata = reg_addr[7:0] ^ 8'h5a;
    tw_link_if link ();
    tw_host tw_host_inst (
        .clk_sys_in(clk_sys_in), .resetn_in(resetn_in), .link(link.host),
        .cmd_valid_in(cmd_valid), .cmd_read_in(cmd_read),
        .cmd_addr_in(cmd_addr), .cmd_count_in(cmd_count),
        .wdata_in(wdata), .cmd_ready_out(cmd_ready),
        .wdata_take_out(wdata_take), .rdata_out(rdata),
        .rdata_valid_out(rdata_valid), .done_out(done));
    tw_dev tw_dev_inst (
        .clk_sys_in(clk_sys_in), .resetn_in(resetn_in), .link(link.dev),
        .reg_rdata_in(reg_rdata), .reg_addr_out(reg_addr),
        .reg_wdata_out(reg_wdata), .reg_wr_out(reg_wr),
        .reg_rd_out(reg_rd), .frame_active_out(frame_active));
    tw_checker tw_checker_inst (
        .clk_sys_in(clk_sys_in), .resetn_in(resetn_in),
        .sel_n(link.sel_n), .sclk(link.sclk),
        .host_sdio_out(link.host_sdio_out), .host_sdio_oe(link.host_sdio_oe),
        .dev_sdio_out(link.dev_sdio_out), .dev_sdio_oe(link.dev_sdio_oe),
        .sdio(link.sdio));
    initial begin
        forever #20 clk_sys_in = ~clk_sys_in;
    end
    // wire watch: first 16 bits of each frame, plus strobes and bytes
    always @(posedge clk_sys_in) begin
        sclk_q <= link.sclk;
        if (link.sel_n) nbits <= 0;
        if (!link.sel_n && link.sclk && !sclk_q && nbits < 16) begin
            instr <= {instr[14:0], link.sdio};
            nbits <= nbits + 1;
        end
        if (reg_wr === 1'b1) begin
            wa_q.push_back(reg_addr);
            wd_q.push_back(reg_wdata);
        end
        if (rdata_valid === 1'b1) rd_q.push_back(rdata);
        if (reg_rd === 1'b1) ra_q.push_back(reg_addr);
    end
    // next write byte ready well before the host samples it
    always @(negedge clk_sys_in) begin
        if (wdata_take === 1'b1) wdata <= wdata + 8'h01;
    end
    task automatic check(input logic [15:0] got, input logic [15:0] exp);
        n_checks++;
        if (got !== exp) begin
            err_total++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic end_sim();
        $display("checks %0d errors %0d", n_checks, err_total);
        if (err_total == 0 && n_checks > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask
    task automatic run_cmd(input logic rd, input logic [12:0] addr,
                           input logic [7:0] n, input logic [7:0] base);
        int i;
        logic [1:0] len;
        logic [12:0] a;
        logic [7:0] nf;
        logic act;
        len = (n > 8'h03) ? 2'h3 : 2'(n - 8'h01);
        act = 1'b0;
        wa_q.delete();
        wd_q.delete();
        rd_q.delete();
        ra_q.delete();
        check(16'(cmd_ready), 16'h0001);
        cmd_valid = 1'b1;
        cmd_read = rd;
        cmd_addr = addr;
        cmd_count = n;
        wdata = base;
        @(negedge clk_sys_in);
        cmd_valid = 1'b0;
        // look between edges, never in the launching edge's time step
        for (i = 0; i < 2000 && done !== 1'b1; i++) begin
            @(negedge clk_sys_in);
            act = act | (frame_active === 1'b1);
        end
        if (i == 2000) begin
            err_total++;
            $display("Error at %0t: command never finished", $time);
            hung = 1'b1;
            return;
        end
        @(negedge clk_sys_in);
        check(16'(act), 16'h0001);
        check(instr, {rd, len, addr});
        check(16'(frame_active), 16'h0000);
        if (rd) begin
            // one fetch per byte, one spare for the open-ended code
            nf = (n > 8'h03) ? n + 8'h01 : n;
            check(16'(ra_q.size()), 16'(nf));
            for (i = 0; i < ra_q.size(); i++) begin
                a = addr + 13'(i);
                check(16'(ra_q[i]), 16'(a));
            end
            check(16'(rd_q.size()), 16'(n));
            for (i = 0; i < rd_q.size(); i++) begin
                a = addr + 13'(i);
                check(16'(rd_q[i]), 16'(a[7:0] ^ 8'h5a));
            end
        end else begin
            check(16'(ra_q.size()), 16'h0000);
            check(16'(wa_q.size()), 16'(n));
            for (i = 0; i < wa_q.size(); i++) begin
                check(16'(wa_q[i]), 16'(addr + 13'(i)));
                check(16'(wd_q[i]), 16'(base + 8'(i)));
            end
        end
    endtask
    initial begin
        int k;
        repeat (3) @(posedge clk_sys_in);
        @(negedge clk_sys_in);
        resetn_in = 1'b1;
        check(16'({link.sel_n, link.sclk}), 16'h0002);
        check(16'(link.dev_sdio_oe), 16'h0000);
        repeat (4) @(negedge clk_sys_in);
        // counts 1..5 both ways, back to back, wrapping the address
        for (k = 0; k < 10 && !hung; k++) begin
            run_cmd(k[0], 13'h1ffc + 13'(k), 8'(k / 2 + 1),
                    8'h3c ^ 8'(k * 17));
        end
        end_sim();
    end
endmodule
